// *** logic/fac_core.sv ***
`timescale 1ns/1ps
module fac_core
    import fac_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
) (
    // Clock, reset and clock enable
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    // Special function register port
    input  wire logic [7:0]              sfr_addr,
    input  wire logic                    sfr_wr,
    input  wire logic                    sfr_rd,
    input  wire logic [7:0]              sfr_wdata,
    output logic      [7:0]              sfr_rdata,
    // Links to the rest of the CRC unit
    input  wire logic                    crc_control_reg_wr,
    input  wire logic                    polynomial_select,
    input  wire logic                    preset_value_select,
    input  wire logic                    result_preset_trigger,
    input  wire logic                    crc_in_wr,
    input  wire logic [7:0]              crc_in_data,
    output logic      [31:0]             crc_result,
    // Program bank register bits used for the upper code bank
    input  wire logic [FAC_BANK_W-1:0]   fetch_bank_select,
    // Flash read port
    output logic                         flash_rd_req,
    output logic      [FAC_PHYS_W-1:0]   flash_addr,
    input  wire logic                    flash_rd_ack,
    input  wire logic [7:0]              flash_rdata,
    // Core stall
    output logic                         cpu_halt
);
    fac_state_type               state_reg;
    fac_state_type               state_next;
    logic                        auto_run_enable_reg;
    logic                        auto_run_enable_next;
    logic [FAC_SECTOR_W-1:0]     start_sector_reg;
    logic [FAC_SECTOR_W-1:0]     start_sector_next;
    logic [FAC_SECTOR_W-1:0]     sector_count_reg;
    logic [FAC_SECTOR_W-1:0]     sector_count_next;
    logic [7:0]                  bit_reverse_byte_reg;
    logic [7:0]                  bit_reverse_byte_next;
    logic [7:0]                  flipped_wdata;
    logic [FAC_ADDR_W-1:0]       fetch_addr_reg;
    logic [FAC_ADDR_W-1:0]       fetch_addr_next;
    logic [FAC_BYTES_W-1:0]      fetch_left_reg;
    logic [FAC_BYTES_W-1:0]      fetch_left_next;
    logic [FAC_BYTES_W-1:0]      feed_left_reg;
    logic [FAC_BYTES_W-1:0]      feed_left_next;
    logic [FAC_BYTES_W-1:0]      run_bytes;
    logic [31:0]                 crc_reg;
    logic [31:0]                 crc_next;
    logic [7:0]                  rdata_reg;
    logic [7:0]                  rdata_next;
    logic                        fifo_in_ready;
    logic                        fifo_out_valid;
    logic                        fifo_out_ready;
    logic [7:0]                  fifo_out_data;
    logic                        feed;
    logic                        start_run;
    logic                        wr_flip;
    logic                        wr_auto;
    logic                        wr_count;

    // Byte update, most significant bit first, for either polynomial length.
    function automatic logic [31:0] crc_byte(input logic [31:0] crc_in,
                                             input logic [7:0]  data,
                                             input logic        short_poly);
        logic [31:0] c32;
        logic [15:0] c16;
        c32 = crc_in ^ {data, 24'h00_0000};
        c16 = crc_in[15:0] ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c32 = c32[31] ? ((c32 << 1) ^ FAC_POLY32) : (c32 << 1);
            c16 = c16[15] ? ((c16 << 1) ^ FAC_POLY16) : (c16 << 1);
        end
        return short_poly ? {16'h0000, c16} : c32;
    endfunction

    assign wr_flip  = sfr_wr && (sfr_addr == FAC_ADDR_FLIP);
    assign wr_auto  = sfr_wr && (sfr_addr == FAC_ADDR_AUTO);
    assign wr_count = sfr_wr && (sfr_addr == FAC_ADDR_COUNT);

    // The mirror is pure wiring, so the stored byte is already reversed.
    for (genvar b = 0; b < 8; b++) begin : g_flip
        assign flipped_wdata[b] = sfr_wdata[7 - b];
    end

    // Both fields zero is the one case that does not follow the sector formula.
    always_comb begin
        if ((start_sector_reg == '0) && (sector_count_reg == '0)) begin
            run_bytes = FAC_FULL_SPACE_BYTES;
        end else begin
            run_bytes = FAC_BYTES_W'({1'b0, sector_count_reg} + 7'd1) << FAC_SECTOR_LOG2;
        end
    end

    assign start_run = crc_control_reg_wr && auto_run_enable_reg && (state_reg == FAC_IDLE);

    // Upper half of the banked space goes to the bank the fetch select names.
    always_comb begin
        if (LARGE_PART && fetch_addr_reg[FAC_ADDR_W-1]) begin
            flash_addr = {fetch_bank_select, fetch_addr_reg[FAC_ADDR_W-2:0]};
        end else begin
            flash_addr = FAC_PHYS_W'(fetch_addr_reg);
        end
    end

    // Requests stop while the FIFO is full, so flash is never read ahead of space.
    assign flash_rd_req   = (state_reg == FAC_RUN) && (fetch_left_reg != '0) && fifo_in_ready;
    assign fifo_out_ready = (state_reg == FAC_RUN) && !crc_in_wr;
    assign feed           = fifo_out_valid && fifo_out_ready;
    assign cpu_halt       = (state_reg == FAC_RUN);
    assign crc_result     = crc_reg;
    assign sfr_rdata      = rdata_reg;

    fac_fifo #(
        .WIDTH (FAC_FIFO_WIDTH),
        .DEPTH (FAC_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (flash_rd_ack && flash_rd_req),
        .in_ready  (fifo_in_ready),
        .in_data   (flash_rdata),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .flush     (start_run)
    );

    // Run sequencing and register writes.
    always_comb begin
        state_next            = state_reg;
        fetch_addr_next       = fetch_addr_reg;
        fetch_left_next       = fetch_left_reg;
        feed_left_next        = feed_left_reg;
        auto_run_enable_next  = auto_run_enable_reg;
        start_sector_next     = start_sector_reg;
        sector_count_next     = sector_count_reg;
        bit_reverse_byte_next = bit_reverse_byte_reg;
        if (wr_auto) begin
            auto_run_enable_next = sfr_wdata[FAC_BIT_ENABLE];
            start_sector_next    = sfr_wdata[FAC_SECTOR_W-1:0];
        end
        if (wr_count) begin
            sector_count_next = sfr_wdata[FAC_SECTOR_W-1:0];
        end
        if (wr_flip) begin
            bit_reverse_byte_next = flipped_wdata;
        end
        unique case (state_reg)
            FAC_IDLE: begin
                if (start_run) begin
                    state_next      = FAC_RUN;
                    fetch_addr_next = {start_sector_reg, 10'h000};
                    fetch_left_next = run_bytes;
                    feed_left_next  = run_bytes;
                end
            end
            FAC_RUN: begin
                if (flash_rd_req && flash_rd_ack) begin
                    fetch_addr_next = fetch_addr_reg + 16'h0001;
                    fetch_left_next = fetch_left_reg - 17'h0_0001;
                end
                if (feed) begin
                    feed_left_next = feed_left_reg - 17'h0_0001;
                    if (feed_left_reg == 17'h0_0001) begin
                        state_next = FAC_IDLE;
                    end
                end
            end
        endcase
    end

    // Result: a preset wins over a byte arriving in the same cycle.
    always_comb begin
        crc_next = crc_reg;
        if (result_preset_trigger) begin
            crc_next = preset_value_select ? FAC_PRESET_1 : FAC_PRESET_0;
        end else if (feed) begin
            crc_next = crc_byte(crc_reg, fifo_out_data, polynomial_select);
        end else if (crc_in_wr) begin
            crc_next = crc_byte(crc_reg, crc_in_data, polynomial_select);
        end
    end

    // Read data is held in a register one cycle after the read strobe.
    always_comb begin
        rdata_next = rdata_reg;
        if (sfr_rd) begin
            unique case (sfr_addr)
                FAC_ADDR_FLIP:  rdata_next = bit_reverse_byte_reg;
                FAC_ADDR_AUTO:  rdata_next = {auto_run_enable_reg, (state_reg == FAC_IDLE),
                                              start_sector_reg};
                FAC_ADDR_COUNT: rdata_next = {2'b00, sector_count_reg};
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg            <= FAC_IDLE;
            auto_run_enable_reg  <= FAC_RESET_AUTO[FAC_BIT_ENABLE];
            start_sector_reg     <= FAC_RESET_AUTO[FAC_SECTOR_W-1:0];
            sector_count_reg     <= FAC_RESET_COUNT[FAC_SECTOR_W-1:0];
            bit_reverse_byte_reg <= FAC_RESET_FLIP;
            fetch_addr_reg       <= '0;
            fetch_left_reg       <= '0;
            feed_left_reg        <= '0;
            crc_reg              <= FAC_PRESET_0;
            rdata_reg            <= 8'h00;
        end else if (clk_en) begin
            state_reg            <= state_next;
            auto_run_enable_reg  <= auto_run_enable_next;
            start_sector_reg     <= start_sector_next;
            sector_count_reg     <= sector_count_next;
            bit_reverse_byte_reg <= bit_reverse_byte_next;
            fetch_addr_reg       <= fetch_addr_next;
            fetch_left_reg       <= fetch_left_next;
            feed_left_reg        <= feed_left_next;
            crc_reg              <= crc_next;
            rdata_reg            <= rdata_next;
        end
    end
endmodule

// *** pkg/fac_pkg.sv ***
// What this block does
// - Control write with auto enable starts flash run
// - Complete flag reads 0 during run, 1 after
// - CPU held halted for the whole run
// - First byte address is start sector times 1024
// - Sectors 32-63 map to selected upper bank
// - Last sector starts at (start plus count) times 1024
// - Start and count zero covers whole 64kB space
// - Count register bits 7:6 read zero, ignore writes
// - Bit reverse register reads back mirrored byte
// - Select bit picks 32-bit or 16-bit polynomial
// - Preset trigger loads all ones or all zeros
package fac_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] FAC_ADDR_FLIP  = 8'h95;
    localparam logic [7:0] FAC_ADDR_AUTO  = 8'h96;
    localparam logic [7:0] FAC_ADDR_COUNT = 8'h97;

    // Reset values.
    localparam logic [7:0] FAC_RESET_FLIP  = 8'h00;
    localparam logic [7:0] FAC_RESET_AUTO  = 8'h40;
    localparam logic [7:0] FAC_RESET_COUNT = 8'h00;

    // Field positions in the auto control register.
    localparam int FAC_BIT_ENABLE   = 7;
    localparam int FAC_BIT_COMPLETE = 6;
    localparam int FAC_SECTOR_W     = 6;

    // Flash geometry: 1024-byte sectors, 64 kB banked space, 128 kB part.
    localparam int FAC_SECTOR_LOG2 = 10;
    localparam int FAC_ADDR_W      = 16;
    localparam int FAC_BYTES_W     = 17;
    localparam int FAC_PHYS_W      = 17;
    localparam int FAC_BANK_W      = 2;
    localparam logic [16:0] FAC_FULL_SPACE_BYTES = 17'h1_0000;

    // Polynomials and preset values.
    localparam logic [31:0] FAC_POLY32   = 32'h04C1_1DB7;
    localparam logic [15:0] FAC_POLY16   = 16'h1021;
    localparam logic [31:0] FAC_PRESET_1 = 32'hFFFF_FFFF;
    localparam logic [31:0] FAC_PRESET_0 = 32'h0000_0000;

    // Data FIFO between flash and the CRC engine.
    localparam int FAC_FIFO_WIDTH = 8;
    localparam int FAC_FIFO_DEPTH = 16;

    typedef enum logic [0:0] {
        FAC_IDLE = 1'b0,
        FAC_RUN  = 1'b1
    } fac_state_type;

endpackage

// *** logic/fac_fifo.sv ***
`timescale 1ns/1ps
module fac_fifo
    import fac_pkg::*;
#(
    parameter int WIDTH = FAC_FIFO_WIDTH,
    parameter int DEPTH = FAC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Flush
    input  wire logic             flush
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_next;
    logic [PTR_W:0]   fill_reg;
    logic [PTR_W:0]   fill_next;
    logic             push;
    logic             pop;

    assign in_ready  = (fill_reg != (PTR_W + 1)'(DEPTH));
    assign out_valid = (fill_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fill_next   = fill_reg;
        if (flush) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            fill_next   = '0;
        end else begin
            if (push) begin
                wr_ptr_next = (wr_ptr_reg == (PTR_W)'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_next = (rd_ptr_reg == (PTR_W)'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            fill_next = fill_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
        end else if (clk_en) begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg   <= fill_next;
            if (push && !flush) begin
                mem_reg[wr_ptr_reg] <= in_data;
            end
        end
    end
endmodule

// *** bench/fac_core_props.sv ***
`timescale 1ns/1ps
module fac_core_props
    import fac_pkg::*;
#(
    parameter bit LARGE_PART = 1'b1
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    // Register port
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    // CRC unit links
    input wire logic        crc_control_reg_wr,
    input wire logic        preset_value_select,
    input wire logic        result_preset_trigger,
    input wire logic [31:0] crc_result,
    input wire logic [1:0]  fetch_bank_select,
    // Flash and core
    input wire logic        flash_rd_req,
    input wire logic [16:0] flash_addr,
    input wire logic        flash_rd_ack,
    input wire logic        cpu_halt
);
    logic        en_reg;
    logic [5:0]  st_reg;
    logic [15:0] first_a;
    logic [16:0] first_phys;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // The control register is internal, so its enable and start fields are mirrored here.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            en_reg <= 1'b0;
            st_reg <= 6'h00;
        end else if (clk_en && sfr_wr && sfr_addr == FAC_ADDR_AUTO) begin
            en_reg <= sfr_wdata[FAC_BIT_ENABLE];
            st_reg <= sfr_wdata[5:0];
        end
    end
    assign first_a    = {st_reg, 10'h000};
    assign first_phys = (LARGE_PART && first_a[15]) ? {fetch_bank_select, first_a[14:0]}
                                                     : {1'b0, first_a};
    function automatic logic [7:0] mirror(input logic [7:0] v);
        return {<<{v}};
    endfunction
    sequence s_start;
        !cpu_halt && crc_control_reg_wr && en_reg && clk_en;
    endsequence
    // A second write to the flip register in between would change what the read returns.
    sequence s_flip_wr_rd;
        sfr_wr && clk_en && sfr_addr == FAC_ADDR_FLIP ##1 !(sfr_wr && sfr_addr == FAC_ADDR_FLIP)
            ##1 sfr_rd && clk_en && !sfr_wr && sfr_addr == FAC_ADDR_FLIP;
    endsequence
    AST_START: assert property (s_start |=> cpu_halt)
        else $error("run did not start on control write");
    AST_NO_START: assert property (!cpu_halt && crc_control_reg_wr && !en_reg |=> !cpu_halt)
        else $error("run started while disabled");
    AST_FIRST_ADDR: assert property (s_start |=> flash_rd_req && flash_addr == first_phys)
        else $error("wrong first flash address");
    AST_ASCEND: assert property (flash_rd_req && flash_rd_ack ##1 flash_rd_req
        |-> flash_addr[9:0] == $past(flash_addr[9:0]) + 10'h001)
        else $error("flash addresses not ascending");
    AST_REQ_IN_RUN: assert property (flash_rd_req |-> cpu_halt)
        else $error("flash read outside halted run");
    AST_FLIP: assert property (s_flip_wr_rd |=> sfr_rdata == mirror($past(sfr_wdata, 3)))
        else $error("bit reverse readback wrong");
    AST_COUNT_TOP: assert property (sfr_rd && clk_en && sfr_addr == FAC_ADDR_COUNT
        |=> sfr_rdata[7:6] == 2'b00)
        else $error("count top bits not zero");
    AST_DONE: assert property (sfr_rd && clk_en && sfr_addr == FAC_ADDR_AUTO
        |=> sfr_rdata[FAC_BIT_COMPLETE] == !$past(cpu_halt))
        else $error("complete flag does not match run state");
    AST_PRESET: assert property (result_preset_trigger && clk_en
        |=> crc_result == ($past(preset_value_select) ? FAC_PRESET_1 : FAC_PRESET_0))
        else $error("preset value wrong");
endmodule
bind fac_core fac_core_props #(.LARGE_PART(LARGE_PART)) u_props (
    .ref_clk, .reset, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .crc_control_reg_wr, .preset_value_select, .result_preset_trigger, .crc_result,
    .fetch_bank_select, .flash_rd_req, .flash_addr, .flash_rd_ack, .cpu_halt
);

// *** bench/fac_flash_model.sv ***
`timescale 1ns/1ps
module fac_flash_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Flash read port
    input  wire logic        flash_rd_req,
    input  wire logic [16:0] flash_addr,
    output logic             flash_rd_ack,
    output logic      [7:0]  flash_rdata,
    // Pace and statistics
    input  wire logic        slow,
    output int               ack_count
);
    logic       phase_reg;
    logic [7:0] last_reg;
    // Content mixes bank, sector and byte bits so a wrong bank or order changes the CRC.
    function automatic logic [7:0] mem_byte(input logic [16:0] a);
        return a[7:0] ^ {a[16:10], a[8]} ^ 8'h5A;
    endfunction
    assign flash_rd_ack = flash_rd_req && (!slow || phase_reg);
    // Between acks the data lines show the inverse of the last byte, never a stale copy.
    assign flash_rdata = flash_rd_ack ? mem_byte(flash_addr) : ~last_reg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_reg <= 1'b0;
            last_reg <= 8'h00;
            ack_count <= 0;
        end else begin
            phase_reg <= ~phase_reg;
            if (flash_rd_ack) begin
                last_reg <= flash_rdata;
                ack_count <= ack_count + 1;
            end
        end
    end
endmodule

// *** bench/fac_core_tb.sv ***
`timescale 1ns/1ps
module fac_core_tb;
    import fac_pkg::*;
    logic        ref_clk;
    logic        reset;
    logic        clk_en;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        crc_control_reg_wr;
    logic        polynomial_select;
    logic        preset_value_select;
    logic        result_preset_trigger;
    logic        crc_in_wr;
    logic [7:0]  crc_in_data;
    logic [31:0] crc_result;
    logic [1:0]  fetch_bank_select;
    logic        flash_rd_req;
    logic [16:0] flash_addr;
    logic        flash_rd_ack;
    logic [7:0]  flash_rdata;
    logic        cpu_halt;
    logic        slow;
    int          flash_acks;
    int          mismatches;
    int          compares;
    int          cycles;
    fac_core u_dut (
        .ref_clk, .reset, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .crc_control_reg_wr, .polynomial_select, .preset_value_select, .result_preset_trigger,
        .crc_in_wr, .crc_in_data, .crc_result, .fetch_bank_select, .flash_rd_req,
        .flash_addr, .flash_rd_ack, .flash_rdata, .cpu_halt
    );
    fac_flash_model u_flash (
        .ref_clk, .reset, .flash_rd_req, .flash_addr, .flash_rd_ack, .flash_rdata, .slow,
        .ack_count(flash_acks)
    );
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // The full-space run alone needs 65536 cycles, so the ceiling sits well above it.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic close_out();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick();
        sfr_wr = 1'b0;
        tick();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick();
        sfr_rd = 1'b0;
        check32({24'h00_0000, sfr_rdata}, {24'h00_0000, exp});
        tick();
    endtask
    task automatic ctl_pulse();
        crc_control_reg_wr = 1'b1;
        tick();
        crc_control_reg_wr = 1'b0;
    endtask
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] d,
                                         input logic p16);
        logic [31:0] r;
        r = p16 ? {16'h0000, c[15:0] ^ {d, 8'h00}} : c ^ {d, 24'h00_0000};
        for (int i = 0; i < 8; i++) begin
            if (p16) r = {16'h0000, r[15] ? {r[14:0], 1'b0} ^ FAC_POLY16 : {r[14:0], 1'b0}};
            else r = r[31] ? {r[30:0], 1'b0} ^ FAC_POLY32 : {r[30:0], 1'b0};
        end
        return r;
    endfunction
    task automatic t_regs();
        rd_chk(FAC_ADDR_FLIP, FAC_RESET_FLIP);
        rd_chk(FAC_ADDR_AUTO, FAC_RESET_AUTO);
        rd_chk(FAC_ADDR_COUNT, FAC_RESET_COUNT);
        wr(FAC_ADDR_COUNT, 8'hFF);
        rd_chk(FAC_ADDR_COUNT, 8'h3F);
        wr(8'h98, 8'hA5);
        rd_chk(8'h98, 8'h00);
        wr(FAC_ADDR_FLIP, 8'hC0);
        rd_chk(FAC_ADDR_FLIP, 8'h03);
        wr(FAC_ADDR_FLIP, 8'h05);
        rd_chk(FAC_ADDR_FLIP, 8'hA0);
        // A write while the clock enable is low must leave the register untouched.
        clk_en = 1'b0;
        wr(FAC_ADDR_FLIP, 8'hFF);
        clk_en = 1'b1;
        rd_chk(FAC_ADDR_FLIP, 8'hA0);
        wr(FAC_ADDR_AUTO, 8'h05);
        rd_chk(FAC_ADDR_AUTO, 8'h45);
        ctl_pulse();
        check32({31'h0, cpu_halt}, 32'h0000_0000);
    endtask
    task automatic t_soft();
        preset_value_select = 1'b0;
        result_preset_trigger = 1'b1;
        tick();
        result_preset_trigger = 1'b0;
        check32(crc_result, FAC_PRESET_0);
        crc_in_data = 8'h31;
        crc_in_wr = 1'b1;
        tick();
        crc_in_wr = 1'b0;
        tick();
        check32(crc_result, fold(FAC_PRESET_0, 8'h31, 1'b0));
    endtask
    task automatic t_run(input logic [5:0] st, input logic [5:0] cnt, input logic p16,
                         input logic [1:0] bank, input logic pace);
        logic [31:0] exp;
        logic [15:0] a;
        int          n;
        int          base;
        n = (st == 6'h00 && cnt == 6'h00) ? 65536 : (cnt + 1) * 1024;
        exp = FAC_PRESET_1;
        for (int i = 0; i < n; i++) begin
            a = 16'(st * 1024 + i);
            exp = fold(exp, u_flash.mem_byte(a[15] ? {bank, a[14:0]} : {1'b0, a}), p16);
        end
        polynomial_select = p16;
        fetch_bank_select = bank;
        slow = pace;
        preset_value_select = 1'b1;
        result_preset_trigger = 1'b1;
        tick();
        result_preset_trigger = 1'b0;
        wr(FAC_ADDR_COUNT, {2'b00, cnt});
        wr(FAC_ADDR_AUTO, {2'b10, st});
        base = flash_acks;
        ctl_pulse();
        check32({31'h0, cpu_halt}, 32'h0000_0001);
        rd_chk(FAC_ADDR_AUTO, {2'b10, st});
        ctl_pulse();
        for (int i = 0; i < 4 * n && cpu_halt; i++) tick();
        check32({31'h0, cpu_halt}, 32'h0000_0000);
        check32(32'(flash_acks - base), 32'(n));
        check32(crc_result, exp);
        rd_chk(FAC_ADDR_AUTO, {2'b11, st});
    endtask
    // A reset in the middle of a run must abort it and restore the result, auto and count registers.
    task automatic t_abort();
        ctl_pulse();
        check32({31'h0, cpu_halt}, 32'h0000_0001);
        repeat (5) tick();
        reset = 1'b1;
        tick();
        reset = 1'b0;
        check32({31'h0, cpu_halt}, 32'h0000_0000);
        check32(crc_result, FAC_PRESET_0);
        rd_chk(FAC_ADDR_AUTO, FAC_RESET_AUTO);
        rd_chk(FAC_ADDR_COUNT, FAC_RESET_COUNT);
    endtask
    initial begin
        {clk_en, reset} = 2'b11;
        {sfr_addr, sfr_wdata, crc_in_data} = '0;
        {sfr_wr, sfr_rd, crc_control_reg_wr, polynomial_select, crc_in_wr} = '0;
        {preset_value_select, result_preset_trigger, fetch_bank_select, slow} = '0;
        {mismatches, compares, cycles} = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        tick();
        t_regs();
        t_soft();
        t_run(6'd3, 6'd1, 1'b0, 2'd0, 1'b0);
        t_run(6'd33, 6'd0, 1'b1, 2'd2, 1'b1);
        t_run(6'd0, 6'd0, 1'b0, 2'd1, 1'b0);
        t_abort();
        close_out();
    end
endmodule
